/* File: ucwh_decoder_model.sv */
// Behavioural model of the ground command decoder that feeds the handler.
// Assumes the bench requests one word at a time and waits for its outcome.
`timescale 1ns/1ns
`default_nettype none
module ucwh_decoder_model (
    input  wire logic       clk_sys,  // System clock
    input  wire logic       sendReq,  // One-cycle request from the bench
    input  wire logic [5:0] trueBits, // Information bits
    input  wire logic       seqBit,   // Sequence flag
    input  wire logic       corrupt,  // Spoil the complement half
    input  wire logic       useB,     // Deliver on line B instead of A
    output logic            cmdIrqA,  // Interrupt line A
    output logic            cmdIrqB,  // Interrupt line B
    output logic [13:0]     cmdWord   // Word, bit 1 at index 0
);
    logic [13:0] next_word;
    // True half and flag on top, their complement below
    always_comb begin
        next_word = {trueBits, seqBit, ~{trueBits, seqBit}};
        next_word[0] = next_word[0] ^ corrupt;
    end
    // Quiet start so the handler never sees an unknown strobe
    initial begin
        cmdIrqA = 1'b0;
        cmdIrqB = 1'b0;
        cmdWord = 14'h0000;
    end
    // Word is only valid with its strobe; inverted afterwards so stale data never passes
    always @(posedge clk_sys) begin
        cmdIrqA <= sendReq & ~useB;
        cmdIrqB <= sendReq & useB;
        cmdWord <= sendReq ? next_word : ~cmdWord;
    end
endmodule
`default_nettype wire

/* File: ucwh_handler.sv */
// Uplink command word handler: interrupt source register, word checks,
// mode and data sequencing, decoder release and telemetry codes.
// Assumes inputs synchronous to clk_sys; one AHB-Lite master; word-only access.
// Behaviour
// - Upper seven bits must equal the complement of the lower seven.
// - Failed word: discard, report error, count it, no release pulse.
// - Error count reaching seven clears it and awaits a new mode word.
// - Error count below seven keeps waiting for the same word again.
// - A good word is classed as mode or data before use.
// - Mode word: check sequence bit, decode six bits, reject unknown, clear errors.
// - Entering a mode sends its status code twice on telemetry.
// - No-data mode releases the decoder only after all checks pass.
// - Data mode releases the decoder once ready for its data count.
// - Data word: check sequence, release, buffer six bits, track remaining.
// - During a routine, mode words other than terminate are ignored.
// - Seven consecutive failures on one data word abandon the routine.
// - Terminate aborts any routine, clears errors, returns idle.
// - Command arrival sets source bit 8; handling starts on that bit.
// - Twelve interrupt sources, found by scanning the source register.
// - After service, suspended main activity resumes where it stopped.
// - Bit 12 highest, bit 1 lowest priority.
// - Decoder lines A and B both set source bit 8.
// - Bit 8 of each data word toggles on successive data words.
// - True bits 14..9, complement bits 7..1.
`timescale 1ns/1ns
`default_nettype none
module ucwh_handler
    import ucwh_pkg::*;
(
    input  wire logic        clk_sys,      // System clock
    input  wire logic        rstn,         // Synchronous reset, active low
    input  wire logic        cmdIrqA,      // Decoder interrupt A pulse
    input  wire logic        cmdIrqB,      // Decoder interrupt B pulse
    input  wire logic [13:0] cmdWord,      // Command word, bit 1 at index 0
    input  wire logic [11:0] otherIrq,     // Other sources, index n-1 = bit n
    output logic             decoder_release_pulse, // One-cycle release
    output logic             tlmValid,     // Telemetry code strobe
    output logic [7:0]       tlmCode,      // Telemetry code
    output logic             mainBusy,     // Low while an interrupt is serviced
    output logic [3:0]       activeIrq,    // Highest pending source number
    input  wire logic        hsel,         // AHB select
    input  wire logic [31:0] haddr,        // AHB address
    input  wire logic [1:0]  htrans,       // AHB transfer type
    input  wire logic        hwrite,       // AHB write
    input  wire logic [2:0]  hsize,        // AHB size, word only
    input  wire logic [31:0] hwdata,       // AHB write data
    input  wire logic        hready,       // AHB ready in
    output logic             hreadyout,    // Always ready
    output logic [31:0]      hrdata,       // AHB read data
    output logic             hresp         // Always OKAY
);
    ucwh_regs_s r;
    ucwh_regs_s next_r;

    logic       wordOk;
    logic       isMode;
    logic [6:0] needLook;
    logic [5:0] trueBits;
    logic       seqBit;
    logic       busTake;
    logic       otherUp;

    // Word field split and checks
    always_comb begin
        trueBits = r.word[13:8];
        seqBit   = r.word[7];
        wordOk   = (r.word[13:7] == ~r.word[6:0]);
        // Mode words arrive when no routine expects data
        isMode   = !r.modeActive || (trueBits == MODE_TERMINATE);
        needLook = ucwh_mode_need(trueBits);
        // Word transfers only; other sizes are never taken
        busTake  = hsel && htrans[1] && hready && (hsize == 3'h2);
        // Any source but the command bit waiting for service
        otherUp  = |(r.irqSrc & 12'hF7F);
    end

    // Highest pending source, bit 12 first
    function automatic logic [3:0] prio(input logic [11:0] s);
        prio = 4'h0;
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (s[i]) begin
                prio = 4'(i + 1);
            end
        end
    endfunction

    // Next-state logic for the whole handler
    always_comb begin
        next_r          = r;
        next_r.relPulse = 1'b0;
        next_r.tlmValid = 1'b0;
        // Sources latch; the command bit ORs both decoder lines
        next_r.irqSrc   = r.irqSrc | otherIrq;
        next_r.irqSrc[IRQ_CMD_BIT-1] = r.irqSrc[IRQ_CMD_BIT-1] | cmdIrqA | cmdIrqB;
        next_r.activeIrq = prio(r.irqSrc);
        if ((cmdIrqA || cmdIrqB) && !r.pendCmd) begin
            next_r.pendCmd = 1'b1;
            next_r.word    = cmdWord;
        end
        unique case (r.state)
            ST_IDLE: begin
                next_r.sysBusy = 1'b1;
                // Other sources are acknowledged as soon as they are seen
                if (r.irqSrc[IRQ_CMD_BIT-1] && r.pendCmd) begin
                    next_r.state   = ST_CHECK;
                    next_r.sysBusy = 1'b0;
                end

                // Servicing another source suspends main activity for a cycle
                if (otherUp) begin
                    next_r.sysBusy = 1'b0;
                end
                next_r.irqSrc = (next_r.irqSrc & 12'h080) | (otherIrq & 12'hF7F);
            end
            ST_CHECK: begin
                next_r.irqSrc[IRQ_CMD_BIT-1] = cmdIrqA | cmdIrqB;   // Clear, set wins
                // A word arriving while this one is read becomes the next one
                next_r.pendCmd = cmdIrqA | cmdIrqB;
                if (cmdIrqA || cmdIrqB) begin
                    next_r.word = cmdWord;
                end

                next_r.state   = ST_IDLE;
                if (!wordOk) begin
                    next_r.tlmValid = 1'b1;
                    next_r.tlmCode  = TLM_ERROR;
                    if (r.errCnt + 3'h1 == ERR_LIMIT) begin
                        next_r.errCnt     = 3'h0;
                        next_r.modeActive = 1'b0;
                    end else begin
                        next_r.errCnt = r.errCnt + 3'h1;
                    end
                end else if (isMode) begin
                    // Terminate is honoured whether a routine runs or not
                    if (trueBits == MODE_TERMINATE) begin
                        next_r.modeActive = 1'b0;
                        next_r.errCnt     = 3'h0;
                        next_r.relPulse   = 1'b1;
                    end else if (needLook[6] || (r.ctrl[0] && seqBit)) begin
                        next_r.tlmValid = 1'b1;
                        next_r.tlmCode  = TLM_BADMODE;
                    end else begin
                        next_r.errCnt = 3'h0;
                        next_r.mode   = trueBits;
                        next_r.need   = needLook[5:0];
                        next_r.got    = 6'h00;
                        next_r.expSeq = 1'b1;
                        next_r.state  = ST_MODE;
                        next_r.sysBusy = 1'b0;
                    end
                end else if (seqBit != r.expSeq) begin
                    next_r.tlmValid = 1'b1;
                    next_r.tlmCode  = TLM_ERROR;
                    if (r.errCnt + 3'h1 == ERR_LIMIT) begin
                        next_r.errCnt     = 3'h0;
                        next_r.modeActive = 1'b0;
                    end else begin
                        next_r.errCnt = r.errCnt + 3'h1;
                    end
                end else begin
                    next_r.relPulse = 1'b1;
                    next_r.payload = trueBits;
                    next_r.expSeq  = ~r.expSeq;
                    next_r.got     = r.got + 6'h01;
                    next_r.errCnt  = 3'h0;
                    if (r.got + 6'h01 == r.need) begin
                        next_r.state   = ST_EXEC;
                        next_r.sysBusy = 1'b0;
                    end
                end
            end
            ST_MODE: begin
                next_r.tlmValid = 1'b1;
                next_r.tlmCode  = TLM_ENTRY_BASE | {2'h0, r.mode};
                next_r.state    = ST_TLM2;
                next_r.sysBusy  = 1'b0;
            end
            ST_TLM2: begin
                next_r.tlmValid = 1'b1;
                next_r.tlmCode  = TLM_ENTRY_BASE | {2'h0, r.mode};
                next_r.sysBusy  = 1'b0;
                if (r.need == 6'h00) begin
                    next_r.state = ST_EXEC;
                end else begin
                    next_r.modeActive = 1'b1;
                    next_r.relPulse   = 1'b1;
                    next_r.state      = ST_IDLE;
                end
            end
            ST_EXEC: begin
                // Routine runs one cycle; release after checks for no-data modes
                if (r.need == 6'h00) begin
                    next_r.relPulse = 1'b1;
                end
                next_r.modeActive = 1'b0;
                next_r.state      = ST_IDLE;
            end
            ST_DATA_WAIT: begin
                next_r.state = ST_IDLE;
            end
        endcase
        if (next_r.tlmValid) begin
            next_r.lastTlm = next_r.tlmCode;
        end
        // Bus address phase capture
        next_r.hsel    = busTake;
        next_r.haddrQ  = haddr[7:0];
        next_r.hwriteQ = hwrite;
        if (r.hsel && r.hwriteQ && r.haddrQ == ADDR_CTRL) begin
            next_r.ctrl = hwdata;
        end
        next_r.hrdata = 32'h0000_0000;
        if (busTake && !hwrite) begin
            unique case (haddr[7:0])
                ADDR_IRQ_SRC: next_r.hrdata = {20'h0_0000, r.irqSrc};
                ADDR_STATUS:  next_r.hrdata = {16'h0000, r.mode, r.errCnt,
                                               r.modeActive, r.expSeq, 5'h00};
                ADDR_DATA:    next_r.hrdata = {20'h0_0000, r.got, r.payload};
                ADDR_CTRL:    next_r.hrdata = r.ctrl;
                ADDR_TLM:     next_r.hrdata = {24'h00_0000, r.lastTlm};
                default:      next_r.hrdata = 32'h0000_0000;
            endcase
        end
        if (!rstn) begin
            next_r       = '0;
            next_r.state = ST_IDLE;
            next_r.ctrl  = CTRL_RESET;
            next_r.sysBusy = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        r <= next_r;
    end

    assign decoder_release_pulse = r.relPulse;
    assign tlmValid  = r.tlmValid;
    assign tlmCode   = r.tlmCode;
    assign mainBusy  = r.sysBusy;
    assign activeIrq = r.activeIrq;
    assign hreadyout = 1'b1;
    assign hrdata    = r.hrdata;
    assign hresp     = 1'b0;


    // Spoiled word never frees the decoder
    a_bad_norelease: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && !wordOk) |=> !decoder_release_pulse)
        else $error("release after bad word");

    // Spoiled word always reported
    a_bad_tlm: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && !wordOk) |=> tlmValid && tlmCode == TLM_ERROR)
        else $error("no error telemetry");

    // Seventh failure wraps the count
    a_err_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && !wordOk && r.errCnt == 3'h6) |=> r.errCnt == 3'h0)
        else $error("error count not cleared");

    // Earlier failures step the count by one
    a_err_step: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && !wordOk && r.errCnt < 3'h6)
        |=> r.errCnt == $past(r.errCnt) + 3'h1)
        else $error("error count not stepped");

    // Entry code goes out on two cycles in a row
    sequence s_entry;
        r.state == ST_MODE ##1 tlmValid ##1 tlmValid;
    endsequence
    a_entry_twice: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && wordOk && !r.modeActive && !needLook[6]
         && !(r.ctrl[0] && seqBit)) |=> s_entry)
        else $error("entry code not sent twice");

    // Terminate stops a running routine
    a_term_abort: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && wordOk && r.modeActive && trueBits == MODE_TERMINATE)
        |=> !r.modeActive && r.errCnt == 3'h0)
        else $error("terminate did not abort");

    // Either decoder line raises the command bit
    a_cmd_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cmdIrqA || cmdIrqB) |=> r.irqSrc[IRQ_CMD_BIT-1])
        else $error("command bit not set");

    // Top source always wins
    a_prio_top: assert property (@(posedge clk_sys) disable iff (!rstn)
        r.irqSrc[11] |=> activeIrq == 4'hC)
        else $error("priority wrong");

    // Pending command leads straight to the word checks
    a_cmd_dispatch: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_IDLE && r.irqSrc[IRQ_CMD_BIT-1] && r.pendCmd)
        |=> r.state == ST_CHECK)
        else $error("command not dispatched");

    // A pending word is only dropped once it has been checked
    a_pend_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.pendCmd && r.state != ST_CHECK) |=> r.pendCmd)
        else $error("pending word lost");

    // Servicing another source drops the busy flag
    a_busy_other: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_IDLE && otherUp) |=> !mainBusy)
        else $error("busy not dropped");

    // Nothing to service: main activity runs on
    a_busy_resume: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_IDLE && !r.pendCmd && !otherUp) |=> mainBusy)
        else $error("main activity not resumed");

    // Unknown mode is reported and not released
    a_mode_bad: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && wordOk && isMode && needLook[6]
         && trueBits != MODE_TERMINATE)
        |=> tlmValid && tlmCode == TLM_BADMODE && !decoder_release_pulse)
        else $error("bad mode not rejected");

    // Running routine keeps its mode against other mode words
    a_mode_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && wordOk && r.modeActive && trueBits != MODE_TERMINATE)
        |=> r.state != ST_MODE && r.mode == $past(r.mode))
        else $error("mode word not ignored");

    // Data mode frees the decoder once set up for data
    a_data_rel: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_TLM2 && r.need != 6'h00)
        |=> decoder_release_pulse && r.modeActive)
        else $error("data mode not released");

    // No-data mode frees the decoder only after its checks
    sequence s_late_release;
        !decoder_release_pulse ##1 decoder_release_pulse;
    endsequence
    a_nodata_late: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_TLM2 && r.need == 6'h00) |=> s_late_release)
        else $error("no-data release early or missing");

    // Data word in sequence is released and buffered
    a_data_take: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && wordOk && !isMode && seqBit == r.expSeq)
        |=> decoder_release_pulse && r.payload == $past(trueBits))
        else $error("data word not taken");

    // Data word out of sequence is a failure
    a_seq_reject: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && wordOk && !isMode && seqBit != r.expSeq)
        |=> tlmValid && tlmCode == TLM_ERROR && !decoder_release_pulse)
        else $error("sequence error not caught");

    // Seventh failure on a data word abandons the routine
    a_abandon: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == ST_CHECK && r.modeActive && r.errCnt == 3'h6
         && (!wordOk || (!isMode && seqBit != r.expSeq)))
        |=> !r.modeActive)
        else $error("routine not abandoned");
endmodule
`default_nettype wire

/* File: ucwh_handler_tb.sv */
// Self-checking bench for the uplink command word handler.
// Assumes the decoder model is compiled first; bus answers are awaited, not timed.
`timescale 1ns/1ns
`default_nettype none
module ucwh_handler_tb;
    import ucwh_pkg::*;
    logic        clk_sys, rel, tlmValid, mainBusy, hreadyout, hresp, cmdIrqA, cmdIrqB;
    logic        rstn = 1'b0, sendReq = 1'b0, seqBit = 1'b0, corrupt = 1'b0, useB = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [5:0]  trueBits = 6'h00, p;
    logic [11:0] otherIrq = 12'h000;
    logic [13:0] cmdWord;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0]  tlmCode, rs = 8'h54, tlmQ[$], expTlm[$];
    logic [3:0]  activeIrq, hi;
    logic [5:0]  dm[5] = '{6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h19};
    int          fails, totalChecks, relCnt, expRel, errCnt, active, need, got, a, b, expSeq;
    int          seqChk = 1;
    bit          busyLow;

    ucwh_decoder_model DUT_PEER (.clk_sys(clk_sys), .sendReq(sendReq), .trueBits(trueBits),
        .seqBit(seqBit), .corrupt(corrupt), .useB(useB), .cmdIrqA(cmdIrqA),
        .cmdIrqB(cmdIrqB), .cmdWord(cmdWord));
    ucwh_handler DUT (.clk_sys(clk_sys), .rstn(rstn), .cmdIrqA(cmdIrqA), .cmdIrqB(cmdIrqB),
        .cmdWord(cmdWord), .otherIrq(otherIrq), .decoder_release_pulse(rel),
        .tlmValid(tlmValid), .tlmCode(tlmCode), .mainBusy(mainBusy), .activeIrq(activeIrq),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Collects every release and telemetry code the handler emits
    always @(posedge clk_sys) begin
        if (rel === 1'b1) relCnt++;
        if (tlmValid === 1'b1) tlmQ.push_back(tlmCode);
    end

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // Payload that cannot be mistaken for the abort code
    function automatic logic [5:0] pl();
        return (rs[5:0] == MODE_TERMINATE) ? 6'h11 : rs[5:0];
    endfunction
    function automatic int needOf(input logic [5:0] m);
        case (m)
            6'h08, 6'h13, 6'h14: return 0;
            6'h09: return 35;
            6'h0A, 6'h0B: return 2;
            6'h0C: return 3;
            6'h19: return 45;
            default: return -1;
        endcase
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Single word transfer; address held until ready, data phase likewise
    task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic stat();
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[9:6], {errCnt[2:0], active[0]});
    endtask
    // Reference behaviour for one word
    task automatic predict(input logic [5:0] t, input logic s, input bit bad);
        expRel = 0;
        expTlm.delete();
        // A data word out of sequence fails like a spoiled one
        if (bad || (active != 0 && t != MODE_TERMINATE && s != expSeq)) begin
            expTlm.push_back(TLM_ERROR);
            errCnt++;
            if (errCnt == 7) begin
                errCnt = 0;
                active = 0;
            end
        end else if (t == MODE_TERMINATE) begin
            expRel = 1;
            errCnt = 0;
            active = 0;
        end else if (active != 0) begin
            expRel = 1;
            errCnt = 0;
            expSeq = !expSeq;
            got++;
            if (got == need) active = 0;
        end else if (needOf(t) < 0 || (seqChk != 0 && s)) begin
            expTlm.push_back(TLM_BADMODE);
        end else begin
            need = needOf(t);
            active = (need > 0);
            got = 0;
            errCnt = 0;
            expSeq = 1;
            expRel = 1;
            repeat (2) expTlm.push_back(TLM_ENTRY_BASE | {2'b00, t});
        end
    endtask
    task automatic send(input logic [5:0] t, input logic s, input bit bad);
        predict(t, s, bad);
        relCnt = 0;
        tlmQ.delete();
        @(posedge clk_sys);
        sendReq <= 1'b1;
        trueBits <= t;
        seqBit <= s;
        corrupt <= bad;
        useB <= rs[0];
        @(posedge clk_sys);
        sendReq <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(relCnt, expRel);
        chk(tlmQ.size(), expTlm.size());
        foreach (expTlm[i]) if (i < tlmQ.size()) chk(tlmQ[i], expTlm[i]);
        rs = lfsr(rs);
    endtask

    // Timeout guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        ahb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk({hreadyout, hresp}, 2'b10);
        ahb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        stat();
        // Seven spoiled words: count climbs, then wraps to zero
        for (int i = 0; i < 7; i++) begin
            send(6'h0A, 1'b0, 1);
            stat();
        end
        ahb(1'b0, ADDR_IRQ_SRC, 32'h0);
        chk(rd[7], 1'b0);
        // Each data mode: entry, one data word, then abort
        foreach (dm[i]) begin
            send(dm[i], 1'b0, 0);
            p = pl();
            send(p, 1'b1, 0);
            ahb(1'b0, ADDR_DATA, 32'h0);
            chk(rd[11:0], {6'h01, p});
            send(MODE_TERMINATE, 1'b0, 0);
            stat();
        end
        // Full routine with a retried word; the next mode proves it finished
        send(6'h0A, 1'b0, 0);
        send(pl(), 1'b1, 0);
        send(pl(), 1'b1, 0);
        send(6'h00, 1'b0, 1);
        send(pl(), 1'b0, 0);
        stat();
        send(6'h08, 1'b0, 0);
        send(6'h13, 1'b0, 0);
        send(6'h14, 1'b0, 0);
        send(6'h01, 1'b0, 0);
        send(6'h3F, 1'b0, 0);
        // Seven failures on one data word abandon the routine
        send(6'h0B, 1'b0, 0);
        repeat (7) send(6'h00, 1'b1, 1);
        stat();
        // Terminate while idle still clears a pending error count
        send(6'h00, 1'b0, 1);
        send(MODE_TERMINATE, 1'b0, 0);
        stat();
        send(6'h08, 1'b0, 0);
        // Sequence check disabled: flagged mode word now accepted
        ahb(1'b1, ADDR_CTRL, 32'h0);
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        seqChk = 0;
        send(6'h14, 1'b1, 0);
        ahb(1'b1, ADDR_CTRL, CTRL_RESET);
        seqChk = 1;
        send(6'h14, 1'b1, 0);
        // Two random sources at once: the higher one wins
        for (int i = 0; i < 6; i++) begin
            a = rs[3:0] % 12;
            b = rs[7:4] % 12;
            if (a == 7) a = 11;
            if (b == 7) b = 0;
            @(posedge clk_sys);
            otherIrq <= (12'h001 << a) | (12'h001 << b);
            @(posedge clk_sys);
            otherIrq <= 12'h000;
            hi = 4'h0;
            busyLow = 0;
            repeat (8) begin
                @(posedge clk_sys);
                if (hi == 4'h0 && activeIrq !== 4'h0) hi = activeIrq;
                if (mainBusy === 1'b0) busyLow = 1;
            end
            chk(hi, ((a > b) ? a : b) + 1);
            chk(busyLow, 1'b1);
            chk(mainBusy, 1'b1);
            rs = lfsr(rs);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: ucwh_pkg.sv */
// Constants, types and register map for the uplink command word handler.
// Assumes a single 100 MHz clock domain and an AHB-Lite register slave.
package ucwh_pkg;
    localparam int unsigned CLK_MHZ         = 100;
    localparam logic [7:0]  ADDR_IRQ_SRC    = 8'h00;  // Interrupt source register, RO
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;  // Handler status, RO
    localparam logic [7:0]  ADDR_DATA       = 8'h08;  // Last data payload and count, RO
    localparam logic [7:0]  ADDR_CTRL       = 8'h0C;  // Mode check control, RW
    localparam logic [7:0]  ADDR_TLM        = 8'h10;  // Last telemetry code, RO
    localparam logic [2:0]  ERR_LIMIT       = 3'h7;
    localparam int unsigned IRQ_CMD_BIT     = 8;
    localparam int unsigned NUM_IRQ         = 12;
    localparam logic [5:0]  MODE_TERMINATE  = 6'h10;
    localparam logic [7:0]  TLM_ERROR       = 8'hE0;
    localparam logic [7:0]  TLM_BADMODE     = 8'hE1;
    localparam logic [7:0]  TLM_ENTRY_BASE  = 8'h40;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam logic [5:0]  CNT_SEQ_UPDATE  = 6'h00;
    localparam logic [5:0]  CNT_NAV_UPDATE  = 6'h23;
    localparam logic [5:0]  CNT_SWITCH_SEL  = 6'h02;
    localparam logic [5:0]  CNT_SECTOR_DUMP = 6'h02;
    localparam logic [5:0]  CNT_TELEM_ONE   = 6'h03;
    localparam logic [5:0]  CNT_TARGET_LOAD = 6'h2D;
    localparam logic [5:0]  CNT_ALT_TB      = 6'h00;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CHECK, ST_MODE, ST_TLM2, ST_DATA_WAIT, ST_EXEC
    } ucwh_state_e;

    typedef struct packed {
        ucwh_state_e state;
        logic        pendCmd;
        logic [13:0] word;
        logic [2:0]  errCnt;
        logic [5:0]  mode;
        logic        modeActive;
        logic [5:0]  need;
        logic [5:0]  got;
        logic        expSeq;
        logic [5:0]  payload;
        logic        relPulse;
        logic        tlmValid;
        logic [7:0]  tlmCode;
        logic [7:0]  lastTlm;
        logic        sysBusy;
        logic [11:0] irqSrc;
        logic        hsel;
        logic [7:0]  haddrQ;
        logic        hwriteQ;
        logic [31:0] hrdata;
        logic [31:0] ctrl;
        logic [3:0]  activeIrq;
    } ucwh_regs_s;

    // Data words required by a mode; bit 6 set marks an unknown mode
    function automatic logic [6:0] ucwh_mode_need(input logic [5:0] m);
        unique case (m)
            6'h08:          ucwh_mode_need = {1'b0, CNT_SEQ_UPDATE};
            6'h09:          ucwh_mode_need = {1'b0, CNT_NAV_UPDATE};
            6'h0A:          ucwh_mode_need = {1'b0, CNT_SWITCH_SEL};
            6'h0B:          ucwh_mode_need = {1'b0, CNT_SECTOR_DUMP};
            6'h0C:          ucwh_mode_need = {1'b0, CNT_TELEM_ONE};
            6'h13, 6'h14:   ucwh_mode_need = {1'b0, CNT_ALT_TB};
            6'h19:          ucwh_mode_need = {1'b0, CNT_TARGET_LOAD};
            default:        ucwh_mode_need = 7'h40;
        endcase
    endfunction
endpackage
